// file: fwsr_defines.svh
/*
 file holds: constants for the flash write-status host controller.
 assumes: included by bare name; ref_clk at 25 MHz.
*/
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH
// =====================================================
// register offsets (axi4-lite byte addresses)
`define FWSR_OFF_CTRL     8'h00
`define FWSR_OFF_ADDR     8'h04
`define FWSR_OFF_DATA     8'h08
`define FWSR_OFF_STATUS   8'h0c
`define FWSR_OFF_RDDATA   8'h10
// =====================================================
// ctrl fields
`define FWSR_CTRL_GO      0
`define FWSR_CTRL_MODE_LO 1
`define FWSR_CTRL_MODE_HI 2
// =====================================================
// flash status bit positions
`define FWSR_POLL_BIT     7
`define FWSR_TOG1_BIT     6
`define FWSR_TMO_BIT      5
`define FWSR_ETMR_BIT     3
`define FWSR_TOG2_BIT     2
// =====================================================
// reset command and bus timing
`define FWSR_RESET_CMD    8'hf0
`define FWSR_STROBE_NS    80
`define FWSR_CLK_NS       40
`define FWSR_STROBE_CYC   ((`FWSR_STROBE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`endif

// file: fwsr_pkg.sv
/*
 file holds: types for the flash write-status host controller.
 assumes: nothing beyond the defines header.
*/
package fwsr_pkg;
   // =====================================================
   // operation kinds chosen by software
   typedef enum logic [1:0] {
      FWSR_OP_TOGGLE = 2'h0,
      FWSR_OP_POLL   = 2'h1,
      FWSR_OP_WRITE  = 2'h2,
      FWSR_OP_READ   = 2'h3
   } fwsr_op_t;
   // =====================================================
   // sequencer states, one bit apart in listed order; the returns to FWSR_IDLE flip two bits
   typedef enum logic [2:0] {
      FWSR_IDLE  = 3'h0,
      FWSR_RD    = 3'h1,
      FWSR_EVAL  = 3'h3,
      FWSR_WR    = 3'h2,
      FWSR_DONE  = 3'h6
   } fwsr_state_t;
   // =====================================================
   // flash pin group
   typedef struct packed {
      logic        chipEn_n;
      logic        outEn_n;
      logic        writeEn_n;
      logic [19:0] addr;
      logic [7:0]  dataOut;
      logic        dataOe;
   } fwsr_flash_t;
   // =====================================================
   // axi4-lite slave outputs
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fwsr_axo_t;
endpackage : fwsr_pkg

// file: fwsr_host.sv
/*
 file holds: host controller that drives a parallel flash, runs the
 toggle-check and polling procedures, and reports over axi4-lite.
 assumes: flash data and ready/busy pins arrive asynchronously and are
 synchronised here; the pull-up on the shared ready/busy line is external.
*/
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fwsr_defines.svh"
// Contract
// [R1] ready/busy is open drain shared line, valid after final write strobe.
// [R2] ready/busy low while flash programs or erases.
// [R3] ready/busy high when array data readable or in standby.
// [R4] toggle one bit inverts per read while operation runs.
// [R5] toggle one bit valid from final write strobe and during timeout.
// [R6] all-protected erase toggles about 100 us then array reads.
// [R7] protected-sector program toggles about 1 us then array reads.
// [R8] toggling stops in erase suspend, resumes in suspend-program.
// [R9] toggle two bit toggles on reads inside sectors selected for erase.
// [R10] host combines both toggle bits for per-sector erase state; status bit 4 here reports only the second toggle bit.
// [R11] host reads twice; unchanged toggle means operation complete.
// [R12] still toggling with timeout flag: recheck, then fail and reset.
// [R13] host restarts whole toggle check after suspending monitoring.
// [R14] timeout flag set when internal pulse limit exceeded.
// [R15] programming a one over a zero halts and raises timeout flag.
// [R16] after timeout failure host issues reset command.
// [R17] erase timer flag zero during acceptance window, one after.
// [R18] host may skip erase timer only if commands under 50 us apart.
// [R19] erase timer one: only erase suspend accepted.
// [R20] host checks acceptance, then erase timer before and after commands.
// [R21] host polls at the valid status address.
// [R22] host rechecks polling bit even when timeout flag is one.
// [R23] polling bit complements programmed bit until programming completes.
module fwsr_host
   import fwsr_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [7:0]    awaddr,
   input  wire logic          awvalid,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   input  wire logic          bready,
   input  wire logic [7:0]    araddr,
   input  wire logic          arvalid,
   input  wire logic          rready,
   output fwsr_pkg::fwsr_axo_t   axo,
   output fwsr_pkg::fwsr_flash_t flash,
   input  wire logic [7:0]    flashDataIn,
   input  wire logic          readyBusyIn
);
   import fwsr_pkg::*;

   // =====================================================
   // state
   typedef struct packed {
      fwsr_axo_t   axo;
      fwsr_flash_t flash;
      fwsr_state_t st;
      fwsr_op_t    op;
      logic [19:0] addrReg;
      logic [7:0]  dataReg;
      logic        busy;
      logic        done;
      logic        fail;
      logic        awGot;
      logic        wGot;
      logic [7:0]  awA;
      logic [31:0] wD;
      logic [3:0]  wS;
      logic [7:0]  rdByte;
      logic [7:0]  prevByte;
      logic [1:0]  nReads;
      logic        recheck;
      logic [2:0]  cyc;
   } fwsr_all_t;

   fwsr_all_t   s;
   fwsr_all_t   next_s;
   logic [7:0]  dSync1;
   logic [7:0]  dSync2;
   logic        rbSync1;
   logic        rbSync2;

   // =====================================================
   // input synchronisers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dSync1  <= 8'h00;
         dSync2  <= 8'h00;
         rbSync1 <= 1'b1;
         rbSync2 <= 1'b1;
      end else begin
         dSync1  <= flashDataIn;
         dSync2  <= dSync1;
         rbSync1 <= readyBusyIn;
         rbSync2 <= rbSync1;
      end
   end

   // =====================================================
   // helpers
   function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
      toggled = a[`FWSR_TOG1_BIT] ^ b[`FWSR_TOG1_BIT];
   endfunction : toggled

   // second toggle bit moving between the last two reads marks a sector under erase
   function automatic logic toggledTwo(input logic [7:0] a, input logic [7:0] b);
      toggledTwo = a[`FWSR_TOG2_BIT] ^ b[`FWSR_TOG2_BIT];
   endfunction : toggledTwo

   // status word: erase timer, sector toggle, ready line, fail, done, busy
   function automatic logic [31:0] statusWord(input fwsr_all_t x, input logic rb);
      statusWord    = 32'h0;
      statusWord[0] = x.busy;
      statusWord[1] = x.done;
      statusWord[2] = x.fail;
      statusWord[3] = rb;                                  // [R1] [R2] [R3]
      statusWord[4] = toggledTwo(x.rdByte, x.prevByte);    // [R10]
      statusWord[5] = x.rdByte[`FWSR_ETMR_BIT];            // [R18] [R20]
   endfunction : statusWord

   // give up after the second failing look and queue the reset command
   function automatic fwsr_all_t giveUp(input fwsr_all_t x);
      giveUp         = x;
      giveUp.fail    = 1'b1;
      giveUp.op      = FWSR_OP_WRITE;
      giveUp.dataReg = `FWSR_RESET_CMD;                   // [R16]
   endfunction : giveUp

   // =====================================================
   // next-state logic
   always_comb begin
      next_s = s;
      // =====================================================
      // axi write channel
      if (s.axo.bvalid && bready) begin
         next_s.axo.bvalid = 1'b0;
      end
      if (awvalid && s.axo.awready) begin
         next_s.awGot       = 1'b1;
         next_s.awA         = awaddr;
         next_s.axo.awready = 1'b0;
      end
      if (wvalid && s.axo.wready) begin
         next_s.wGot       = 1'b1;
         next_s.wD         = wdata;
         next_s.wS         = wstrb;
         next_s.axo.wready = 1'b0;
      end
      if (s.awGot && s.wGot && !s.axo.bvalid) begin
         next_s.awGot       = 1'b0;
         next_s.wGot        = 1'b0;
         next_s.axo.awready = 1'b1;
         next_s.axo.wready  = 1'b1;
         next_s.axo.bvalid  = 1'b1;
         next_s.axo.bresp   = 2'h0;
         case (s.awA)
            `FWSR_OFF_CTRL: begin
               if (s.wS[0] && s.wD[`FWSR_CTRL_GO] && !s.busy) begin
                  next_s.op      = fwsr_op_t'(s.wD[`FWSR_CTRL_MODE_HI:`FWSR_CTRL_MODE_LO]);
                  next_s.busy    = 1'b1;
                  next_s.done    = 1'b0;
                  next_s.fail    = 1'b0;
                  next_s.nReads  = 2'h0;  // [R13]
                  next_s.recheck = 1'b0;
               end
            end
            `FWSR_OFF_ADDR: begin
               if (s.wS[0]) next_s.addrReg = s.wD[19:0];
            end
            `FWSR_OFF_DATA: begin
               if (s.wS[0]) next_s.dataReg = s.wD[7:0];
            end
            `FWSR_OFF_STATUS, `FWSR_OFF_RDDATA: begin
               next_s.axo.bresp = 2'h0;
            end
            default: begin
               next_s.axo.bresp = 2'h2;
            end
         endcase
      end
      // =====================================================
      // axi read channel
      if (s.axo.rvalid && rready) begin
         next_s.axo.rvalid  = 1'b0;
         next_s.axo.arready = 1'b1;
      end
      if (arvalid && s.axo.arready) begin
         next_s.axo.arready = 1'b0;
         next_s.axo.rvalid  = 1'b1;
         next_s.axo.rresp   = 2'h0;
         case (araddr)
            `FWSR_OFF_CTRL:   next_s.axo.rdata = {29'h0, s.op, s.busy};
            `FWSR_OFF_ADDR:   next_s.axo.rdata = {12'h0, s.addrReg};
            `FWSR_OFF_DATA:   next_s.axo.rdata = {24'h0, s.dataReg};
            `FWSR_OFF_STATUS: next_s.axo.rdata = statusWord(s, rbSync2); // [R10] [R18] [R20]
            `FWSR_OFF_RDDATA: next_s.axo.rdata = {24'h0, s.rdByte};
            default: begin
               next_s.axo.rdata = 32'h0;
               next_s.axo.rresp = 2'h2;
            end
         endcase
      end
      // =====================================================
      // flash sequencer
      case (s.st)
         FWSR_IDLE: begin
            next_s.flash = '{chipEn_n: 1'b1, outEn_n: 1'b1, writeEn_n: 1'b1,
                             addr: s.addrReg, dataOut: s.dataReg, dataOe: 1'b0};
            if (s.busy && s.op == FWSR_OP_WRITE) begin
               next_s.st              = FWSR_WR;
               next_s.cyc             = 3'h0;
               next_s.flash.chipEn_n  = 1'b0;
               next_s.flash.writeEn_n = 1'b0;
               next_s.flash.dataOe    = 1'b1;
            end else if (s.busy) begin
               next_s.st             = FWSR_RD;
               next_s.cyc            = 3'h0;
               next_s.flash.chipEn_n = 1'b0;
               next_s.flash.outEn_n  = 1'b0;  // [R21]
            end
         end
         FWSR_RD: begin
            next_s.cyc = s.cyc + 3'h1;
            if (s.cyc == 3'(`FWSR_STROBE_CYC + 2)) begin
               next_s.flash.chipEn_n = 1'b1;
               next_s.flash.outEn_n  = 1'b1;
               next_s.prevByte       = s.rdByte;
               next_s.rdByte         = dSync2;
               next_s.nReads         = (s.nReads == 2'h3) ? 2'h3 : s.nReads + 2'h1;
               next_s.st             = FWSR_EVAL;
            end
         end
         FWSR_EVAL: begin
            next_s.st = FWSR_IDLE;
            case (s.op)
               FWSR_OP_READ: begin
                  next_s.busy = 1'b0;
                  next_s.done = 1'b1;
               end
               FWSR_OP_TOGGLE: if (s.nReads >= 2'h2) begin
                  if (!toggled(s.rdByte, s.prevByte)) begin // [R11] [R4]
                     next_s.busy = 1'b0;
                     next_s.done = 1'b1;
                  end else if (s.recheck) begin // [R12] [R16]
                     next_s = giveUp(next_s);
                  end else if (s.rdByte[`FWSR_TMO_BIT]) begin // [R14]
                     next_s.recheck = 1'b1;
                  end
               end
               FWSR_OP_POLL: begin
                  if (s.rdByte[`FWSR_POLL_BIT] == s.dataReg[`FWSR_POLL_BIT]) begin // [R23]
                     next_s.busy = 1'b0;
                     next_s.done = 1'b1;
                  end else if (s.recheck) begin // [R22] [R16]
                     next_s = giveUp(next_s);
                  end else if (s.rdByte[`FWSR_TMO_BIT]) begin
                     next_s.recheck = 1'b1;
                  end
               end
               default: next_s.busy = 1'b0;
            endcase
         end
         FWSR_WR: begin
            next_s.cyc = s.cyc + 3'h1;
            if (s.cyc == 3'(`FWSR_STROBE_CYC)) begin
               next_s.flash.writeEn_n = 1'b1;
               next_s.flash.chipEn_n  = 1'b1;
               next_s.st              = FWSR_DONE;
            end
         end
         FWSR_DONE: begin
            next_s.flash.dataOe = 1'b0;
            next_s.busy         = 1'b0;
            next_s.done         = 1'b1;
            next_s.st           = FWSR_IDLE;
         end
         default: next_s.st = FWSR_IDLE;
      endcase
   end

   // =====================================================
   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s             <= '0;
         s.st          <= FWSR_IDLE;
         s.axo.awready <= 1'b1;
         s.axo.wready  <= 1'b1;
         s.axo.arready <= 1'b1;
         s.flash       <= '{chipEn_n: 1'b1, outEn_n: 1'b1, writeEn_n: 1'b1,
                            addr: 20'h0, dataOut: 8'h0, dataOe: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // =====================================================
   // outputs straight from the state register
   assign axo   = s.axo;
   assign flash = s.flash;
endmodule : fwsr_host

// file: fwsr_host_props.sv
/*
 holds: concurrent checks on the host controller ports.
 assumes: bound from the bench top; one clock domain.
*/
`timescale 1ns/1ps
// =====================================================
// checker
module fwsr_host_props
   import fwsr_pkg::*;
(
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic                  bready,
   input wire logic                  rready,
   input wire fwsr_pkg::fwsr_axo_t   axo,
   input wire fwsr_pkg::fwsr_flash_t flash
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_bresp_held: assert property (axo.bvalid && !bready |=> axo.bvalid && $stable(axo.bresp))
      else $error("write response dropped");
   a_rdata_held: assert property (axo.rvalid && !rready |=> axo.rvalid && $stable(axo.rdata))
      else $error("read data dropped");
   a_read_blocks: assert property (axo.rvalid |-> !axo.arready)
      else $error("address taken during read answer");
   a_read_clean: assert property (!flash.outEn_n |-> flash.writeEn_n && !flash.dataOe)
      else $error("read strobe with write or drive");
   a_write_drive: assert property (!flash.writeEn_n |-> flash.dataOe && !flash.chipEn_n)
      else $error("write strobe without data");
   a_read_len: assert property ($fell(flash.outEn_n) |-> !flash.outEn_n [*5])
      else $error("read strobe short");
   a_write_len: assert property ($fell(flash.writeEn_n) |-> !flash.writeEn_n [*3])
      else $error("write strobe short");
   a_status_addr: assert property (!flash.outEn_n && $past(!flash.outEn_n) |-> $stable(flash.addr))
      else $error("address moved in read");
   a_data_held: assert property (!flash.writeEn_n && $past(!flash.writeEn_n) |-> $stable(flash.dataOut))
      else $error("data moved in write");
   cover property ($fell(flash.outEn_n));
   cover property ($fell(flash.writeEn_n));
   cover property (axo.bvalid && bready);
   cover property (axo.rvalid && !rready);
endmodule : fwsr_host_props

// file: fwsr_flash_model.sv
/*
 holds: behavioural flash status model on the parallel pins.
 assumes: bench calls start to begin an embedded operation.
*/
`timescale 1ns/1ps
`include "fwsr_defines.svh"
// =====================================================
// flash model
module fwsr_flash_model
   import fwsr_pkg::*;
(
   input  wire fwsr_pkg::fwsr_flash_t flash,
   output logic [7:0]                 dataIn,
   output logic                       readyBusy
);
   int          left;
   int          reads;
   logic        tmo;
   logic        tg;
   logic [7:0]  arr;
   logic [7:0]  stat;
   logic [7:0]  wrData;
   logic [19:0] wrAddr;
   logic [19:0] rdAddr;
   wire rdOn = !flash.chipEn_n && !flash.outEn_n;
   wire wrOn = !flash.chipEn_n && !flash.writeEn_n;
   initial begin
      left = 0;
      reads = 0;
      tmo = 1'h0;
      tg = 1'h0;
      arr = 8'h00;
   end
   // status while busy, array byte when idle
   assign stat = (left > 0) ? {~arr[7], tg, tmo, 1'h0, 1'h1, tg, 2'h0} : arr;
   // released bus shows the inverse
   assign dataIn = rdOn ? stat : ~stat;
   // open drain with pull-up: low only while busy
   assign readyBusy = !(left > 0);
   // toggle per read, stop after n reads
   always @(negedge rdOn) begin
      rdAddr = flash.addr;
      reads++;
      if (left > 0) begin
         tg = ~tg;
         left--;
      end
   end
   // bytes latch as the write strobe ends; busy without a limit fault ignores commands
   always @(negedge wrOn) begin
      wrAddr = flash.addr;
      wrData = flash.dataOut;
      if (wrData == `FWSR_RESET_CMD && (left == 0 || tmo)) begin
         left = 0;
         tmo = 1'h0;
      end
   end
   task start(input int n, input logic t, input logic [7:0] a);
      left = n;
      tmo = t;
      arr = a;
      reads = 0;
   endtask : start
endmodule : fwsr_flash_model

// file: fwsr_host_tb_top.sv
/*
 holds: self-checking bench for the host controller.
 assumes: flash model on the far side; axi4-lite master tasks here.
*/
`timescale 1ns/1ps
`include "fwsr_defines.svh"
// =====================================================
// bench
module fwsr_host_tb_top;
   import fwsr_pkg::*;
   logic        ref_clk;
   logic        rst;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic [31:0] wdata;
   logic [31:0] rdWord;
   logic [3:0]  wstrb;
   logic [1:0]  resp;
   logic        slowAck;
   fwsr_axo_t   axo;
   fwsr_flash_t flash;
   logic [7:0]  flashDataIn;
   logic        readyBusyIn;
   int          fails = 0;
   int          total_checks = 0;
   fwsr_host fwsr_host_inst (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .rready(rready), .axo(axo), .flash(flash),
      .flashDataIn(flashDataIn), .readyBusyIn(readyBusyIn));
   fwsr_flash_model fwsr_flash_model_inst (.flash(flash), .dataIn(flashDataIn),
      .readyBusy(readyBusyIn));
   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= !slowAck;
      do begin
         @(posedge ref_clk);
         if (awvalid && axo.awready) awvalid <= 1'h0;
         if (wvalid && axo.wready) wvalid <= 1'h0;
      end while (!axo.bvalid);
      if (slowAck) begin
         bready <= 1'h1;
         @(posedge ref_clk);
      end
      resp = axo.bresp;
      bready <= 1'h0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= !slowAck;
      do begin
         @(posedge ref_clk);
         if (arvalid && axo.arready) arvalid <= 1'h0;
      end while (!axo.rvalid);
      if (slowAck) begin
         rready <= 1'h1;
         @(posedge ref_clk);
      end
      rdWord = axo.rdata;
      resp = axo.rresp;
      rready <= 1'h0;
   endtask : rdr
   // start a flash operation, then poll status until done and idle
   task automatic run(input logic [1:0] op, input int n, input logic t, input logic [7:0] a);
      fwsr_flash_model_inst.start(n, t, a);
      wr(`FWSR_OFF_CTRL, {29'h0, op, 1'h1});
      do rdr(`FWSR_OFF_STATUS); while (rdWord[0] !== 1'h0 || rdWord[1] !== 1'h1);
      $display("test op %0d ends", op);
   endtask : run
   initial begin
      repeat (90000) @(posedge ref_clk);
      fails++;
      $display("wrong value at %0t: timeout", $time);
      summarize();
   end
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      slowAck = 1'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      rdr(`FWSR_OFF_STATUS);
      chk(rdWord, 32'h8, "status at reset");
      slowAck = 1'h1;
      rdr(8'h20);
      chk(rdWord, 32'h0, "unmapped read data");
      chk(resp, 32'h2, "unmapped read resp");
      wr(8'h24, 32'h0);
      chk(resp, 32'h2, "unmapped write");
      slowAck = 1'h0;
      $display("test bus ends");
      run(2'h0, 4, 1'h0, 8'h41);
      chk(rdWord[3:2], 2'h2, "toggle done");
      chk(fwsr_flash_model_inst.reads > 4, 1, "toggle reads");
      chk(rdWord[5:4], 2'h1, "sector toggle at done");
      run(2'h0, 1000, 1'h1, 8'h41);
      chk(rdWord[2], 1, "toggle fail");
      chk(rdWord[5:4], 2'h3, "sector toggle and timer");
      chk(fwsr_flash_model_inst.wrData, 32'hf0, "reset after toggle");
      wr(`FWSR_OFF_ADDR, 32'h12345);
      wr(`FWSR_OFF_DATA, 32'ha5);
      run(2'h1, 3, 1'h0, 8'ha5);
      chk(rdWord[2], 0, "poll done");
      chk(fwsr_flash_model_inst.rdAddr, 32'h12345, "poll address");
      run(2'h1, 1000, 1'h1, 8'ha5);
      chk(rdWord[2], 1, "poll fail");
      chk(fwsr_flash_model_inst.wrAddr, 32'h12345, "reset address");
      wr(`FWSR_OFF_DATA, 32'h3c);
      run(2'h2, 0, 1'h0, 8'h00);
      chk(fwsr_flash_model_inst.wrData, 32'h3c, "single write");
      run(2'h3, 0, 1'h0, 8'h96);
      rdr(`FWSR_OFF_RDDATA);
      chk(rdWord, 32'h96, "single read");
      summarize();
   end
endmodule : fwsr_host_tb_top
bind fwsr_host fwsr_host_props fwsr_host_props_inst (.ref_clk(ref_clk), .rst(rst),
   .bready(bready), .rready(rready), .axo(axo), .flash(flash));
